// [hdl/scc_top.sv]
`timescale 1ns/100ps
`default_nettype none
module scc_top
	import scc_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int STOP_TICKS = SCC_STOP_TICKS
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic OSC_DET_RESET,
	// register port
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// system inputs
	input wire logic CLOCK_CHANGE_LOCK,
	input wire logic DIV8_SELECT,
	input wire logic WAKE_EVENT,
	input wire logic SUB_OSC_ENABLE,
	input wire logic ONCHIP_OSC_TICK,
	input wire logic MAIN_OSC_IN,
	// clock tree control
	output scc_src_type SYS_SRC_SEL,
	output logic [4:0] MAIN_DIV_RATIO,
	output logic MAIN_OSC_DRIVE_HIGH,
	output logic ONCHIP_OSC_EN,
	output logic STOP_MODE,
	// oscillator pins
	output logic MAIN_OSC_OUT_HOLD,
	output logic FEEDBACK_EN,
	output logic SUB_OSC_IN_OE,
	output logic SUB_OSC_OUT_OE,
	// detection results
	output logic OSC_DETECT_IRQ,
	output logic OSC_DETECT_RST_REQ
);
	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic stop_reg, pll_reg, ocostop_reg, drive_reg;
	logic [1:0] div_reg, rsv1_reg, rsv2_reg;
	logic deten_reg, ocosel_reg, flag_reg, action_reg;
	logic wr1, wr2, rd1, rd2;
	logic mon_stopped, mon_stop_evt, mon_reosc_evt;
	logic det_evt, auto_oco;

	assign wr1 = WR && ADDR == ADDR_W'(SCC_CTRL1_OFS);
	assign wr2 = WR && ADDR == ADDR_W'(SCC_DETCTL_OFS);
	assign rd1 = RD && ADDR == ADDR_W'(SCC_CTRL1_OFS);
	assign rd2 = RD && ADDR == ADDR_W'(SCC_DETCTL_OFS);

	// detector events count only while detection is on
	assign det_evt = deten_reg && (mon_stop_evt || mon_reosc_evt);
	assign auto_oco = deten_reg && action_reg && !pll_reg &&
		mon_stop_evt;

	// ------------------------------------------------------------
	// oscillation detector, timed by on-chip oscillator ticks
	// ------------------------------------------------------------
	scc_osc_monitor #(
		.STOP_TICKS(STOP_TICKS)
	) u_mon (
		.clk(SYS_CLK),
		.rst_n(NRST),
		.onchip_tick(ONCHIP_OSC_TICK && !ocostop_reg),
		.main_osc_level(MAIN_OSC_IN),
		.stopped(mon_stopped),
		.stop_evt(mon_stop_evt),
		.reosc_evt(mon_reosc_evt)
	);

	// ------------------------------------------------------------
	// system_clock_control_one
	// ------------------------------------------------------------
	// stop bit: set by software, released by a wake event
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			stop_reg <= SCC_CTRL1_RST[SCC_B_STOP];
		end else if (WAKE_EVENT) begin
			stop_reg <= 1'b0;
		end else if (wr1) begin
			stop_reg <= WDATA[SCC_B_STOP];
		end
	end

	// remaining control fields
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			pll_reg <= SCC_CTRL1_RST[SCC_B_PLL];
			rsv1_reg <= SCC_CTRL1_RST[SCC_B_RSV1_HI:SCC_B_RSV1_LO];
			ocostop_reg <= SCC_CTRL1_RST[SCC_B_OCOSTOP];
			drive_reg <= SCC_CTRL1_RST[SCC_B_DRIVE];
			div_reg <= SCC_CTRL1_RST[SCC_B_DIV_HI:SCC_B_DIV_LO];
		end else if (wr1) begin
			pll_reg <= WDATA[SCC_B_PLL];
			rsv1_reg <= WDATA[SCC_B_RSV1_HI:SCC_B_RSV1_LO];
			ocostop_reg <= WDATA[SCC_B_OCOSTOP];
			drive_reg <= WDATA[SCC_B_DRIVE] ||
				WDATA[SCC_B_STOP];
			div_reg <= WDATA[SCC_B_DIV_HI:SCC_B_DIV_LO];
		end
	end

	// ------------------------------------------------------------
	// oscillation_detect_control
	// ------------------------------------------------------------
	// retained bits keep their value through a detection reset
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			if (!OSC_DET_RESET) begin
				deten_reg <= SCC_DETCTL_RST[SCC_B_DETEN];
				ocosel_reg <= SCC_DETCTL_RST[SCC_B_OCOSEL];
				action_reg <= SCC_DETCTL_RST[SCC_B_ACTION];
			end
		end else begin
			if (wr2 && !CLOCK_CHANGE_LOCK) begin
				deten_reg <= WDATA[SCC_B_DETEN];
			end
			if (auto_oco) begin
				ocosel_reg <= 1'b1;
			end else if (wr2) begin
				ocosel_reg <= WDATA[SCC_B_OCOSEL];
			end
			if (wr2) begin
				action_reg <= WDATA[SCC_B_ACTION];
			end
		end
	end

	// reserved pair stores what is written
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			rsv2_reg <= SCC_DETCTL_RST[SCC_B_RSV2_HI:SCC_B_RSV2_LO];
		end else if (wr2) begin
			rsv2_reg <= WDATA[SCC_B_RSV2_HI:SCC_B_RSV2_LO];
		end
	end

	// flag: a detection beats a clearing write, writing 1 is ignored
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			flag_reg <= SCC_DETCTL_RST[SCC_B_FLAG];
		end else if (det_evt) begin
			flag_reg <= 1'b1;
		end else if (wr2 && !WDATA[SCC_B_FLAG]) begin
			flag_reg <= 1'b0;
		end
	end

	// interrupt pulse on a 0-to-1 flag edge, reset request on stop
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			OSC_DETECT_IRQ <= 1'b0;
			OSC_DETECT_RST_REQ <= 1'b0;
		end else begin
			OSC_DETECT_IRQ <= det_evt && !flag_reg && action_reg;
			OSC_DETECT_RST_REQ <= deten_reg && !action_reg &&
				mon_stop_evt;
		end
	end

	// ------------------------------------------------------------
	// clock tree outputs
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			SYS_SRC_SEL <= SCC_SRC_MAIN;
			MAIN_DIV_RATIO <= SCC_DIV_8;
			MAIN_OSC_DRIVE_HIGH <= SCC_CTRL1_RST[SCC_B_DRIVE];
			ONCHIP_OSC_EN <= 1'b1;
		end else begin
			if (ocosel_reg) begin
				SYS_SRC_SEL <= SCC_SRC_ONCHIP;
			end else if (pll_reg) begin
				SYS_SRC_SEL <= SCC_SRC_PLL;
			end else begin
				SYS_SRC_SEL <= SCC_SRC_MAIN;
			end
			if (DIV8_SELECT) begin
				MAIN_DIV_RATIO <= SCC_DIV_8;
			end else begin
				case (div_reg)
					2'b00: MAIN_DIV_RATIO <= SCC_DIV_1;
					2'b01: MAIN_DIV_RATIO <= SCC_DIV_2;
					2'b10: MAIN_DIV_RATIO <= SCC_DIV_4;
					default: MAIN_DIV_RATIO <= SCC_DIV_16;
				endcase
			end
			MAIN_OSC_DRIVE_HIGH <= drive_reg;
			ONCHIP_OSC_EN <= !ocostop_reg && !stop_reg;
		end
	end

	// stop mode and oscillator pin states
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			STOP_MODE <= 1'b0;
			MAIN_OSC_OUT_HOLD <= 1'b0;
			FEEDBACK_EN <= 1'b1;
			SUB_OSC_IN_OE <= 1'b0;
			SUB_OSC_OUT_OE <= 1'b0;
		end else begin
			STOP_MODE <= stop_reg;
			MAIN_OSC_OUT_HOLD <= stop_reg;
			FEEDBACK_EN <= !stop_reg;
			SUB_OSC_IN_OE <= SUB_OSC_ENABLE && !stop_reg;
			SUB_OSC_OUT_OE <= SUB_OSC_ENABLE && !stop_reg;
		end
	end

	// ------------------------------------------------------------
	// read port, data in the cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			RDATA <= 8'h00;
		end else if (rd1) begin
			RDATA <= {div_reg, drive_reg, ocostop_reg, rsv1_reg, pll_reg,
				stop_reg};
		end else if (rd2) begin
			// bit 6 has no storage and returns 0
			RDATA <= {action_reg, 1'b0, rsv2_reg, mon_stopped, flag_reg,
				ocosel_reg, deten_reg};
		end else begin
			RDATA <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_stop_enter;
		@(posedge SYS_CLK) disable iff (!NRST)
		(wr1 && WDATA[SCC_B_STOP] && !WAKE_EVENT) |=> ##1 STOP_MODE;
	endproperty
	a_stop_enter: assert property (p_stop_enter)
		else $error("stop write did not enter stop mode");

	property p_src_pll;
		@(posedge SYS_CLK) disable iff (!NRST)
		(pll_reg && !ocosel_reg) |=> SYS_SRC_SEL == SCC_SRC_PLL;
	endproperty
	a_src_pll: assert property (p_src_pll)
		else $error("PLL source not routed");

	property p_div8;
		@(posedge SYS_CLK) disable iff (!NRST)
		DIV8_SELECT |=> MAIN_DIV_RATIO == SCC_DIV_8;
	endproperty
	a_div8: assert property (p_div8)
		else $error("divide by 8 not applied");

	property p_div16;
		@(posedge SYS_CLK) disable iff (!NRST)
		(!DIV8_SELECT && div_reg == 2'b11) |=> MAIN_DIV_RATIO == SCC_DIV_16;
	endproperty
	a_div16: assert property (p_div16)
		else $error("divide by 16 not applied");

	property p_stop_pins;
		@(posedge SYS_CLK) disable iff (!NRST)
		STOP_MODE |-> (MAIN_OSC_OUT_HOLD && !FEEDBACK_EN &&
			!SUB_OSC_IN_OE && !SUB_OSC_OUT_OE);
	endproperty
	a_stop_pins: assert property (p_stop_pins)
		else $error("oscillator pins wrong in stop mode");

	property p_monitor_read;
		@(posedge SYS_CLK) disable iff (!NRST)
		rd2 |=> RDATA[SCC_B_MON] == $past(mon_stopped);
	endproperty
	a_monitor_read: assert property (p_monitor_read)
		else $error("monitor bit does not show oscillator state");

	property p_flag_write1;
		@(posedge SYS_CLK) disable iff (!NRST)
		(flag_reg && wr2 && WDATA[SCC_B_FLAG]) |=> flag_reg;
	endproperty
	a_flag_write1: assert property (p_flag_write1)
		else $error("writing 1 changed the detection flag");

	property p_irq_edge;
		@(posedge SYS_CLK) disable iff (!NRST)
		OSC_DETECT_IRQ |->
			(flag_reg && !$past(flag_reg) && $past(action_reg));
	endproperty
	a_irq_edge: assert property (p_irq_edge)
		else $error("interrupt without a flag rising edge");

	property p_reset_req;
		@(posedge SYS_CLK) disable iff (!NRST)
		(deten_reg && !action_reg && mon_stop_evt) |=> OSC_DETECT_RST_REQ;
	endproperty
	a_reset_req: assert property (p_reset_req)
		else $error("stop detection did not request reset");

	property p_auto_onchip;
		@(posedge SYS_CLK) disable iff (!NRST)
		auto_oco |=> ocosel_reg ##1 SYS_SRC_SEL == SCC_SRC_ONCHIP;
	endproperty
	a_auto_onchip: assert property (p_auto_onchip)
		else $error("stop did not switch to on-chip oscillator");

	property p_lock;
		@(posedge SYS_CLK) disable iff (!NRST)
		(wr2 && CLOCK_CHANGE_LOCK) |=> $stable(deten_reg);
	endproperty
	a_lock: assert property (p_lock)
		else $error("locked detection enable was written");

	c_stop: cover property (@(posedge SYS_CLK) disable iff (!NRST)
		STOP_MODE ##1 !STOP_MODE);
	c_irq: cover property (@(posedge SYS_CLK) disable iff (!NRST)
		OSC_DETECT_IRQ);
	c_rst_req: cover property (@(posedge SYS_CLK) disable iff (!NRST)
		OSC_DETECT_RST_REQ);
endmodule
`default_nettype wire

// [hdl/scc_pkg.sv]
// Function
// - writing 1 to all_clock_stop halts all clocks and enters stop mode
// - pll_source_select 0 picks main oscillator, 1 picks PLL clock
// - onchip_osc_stop 0 keeps 125 kHz oscillator running outside stop mode, 1 stops it
// - main_osc_drive_high 0 gives low drive unless all_clock_stop is written 1 in the same write, 1 gives high drive
// - division field bits 7:6 give divide by 1, 2, 4 or 16
// - division field applies only while div8_select is 0, else divide by 8
// - stop mode holds main_osc_out high and disconnects feedback resistor
// - stop mode leaves both sub oscillator pins undriven
// - osc_stop_detect_enable switches the stop/restart detector on or off
// - onchip_osc_source_select 0 routes main/PLL, 1 routes 125 kHz clock
// - osc_stop_detect_flag reads 1 once stop or restart was detected
// - main_osc_monitor is read-only live state, 1 while main clock stopped
// - bit 6 of detection control has no storage and reads 0
// - detect_action_select 0 requests reset on stop, 1 raises interrupt
// - flag clears only by writing 0; with detect_action_select 1 each 0-to-1 edge raises interrupt
// - interrupt action and main source: a stop sets onchip source select
// - clock_change_lock blocks writes to osc_stop_detect_enable
// - enable, onchip select and action bits survive detection reset
package scc_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] SCC_CTRL1_OFS = 8'h07;
	localparam logic [7:0] SCC_DETCTL_OFS = 8'h0C;
	localparam logic [7:0] SCC_CTRL1_RST = 8'h20;
	localparam logic [7:0] SCC_DETCTL_RST = 8'h00;
	// system_clock_control_one fields
	localparam int SCC_B_STOP = 0;
	localparam int SCC_B_PLL = 1;
	localparam int SCC_B_RSV1_LO = 2;
	localparam int SCC_B_RSV1_HI = 3;
	localparam int SCC_B_OCOSTOP = 4;
	localparam int SCC_B_DRIVE = 5;
	localparam int SCC_B_DIV_LO = 6;
	localparam int SCC_B_DIV_HI = 7;
	// oscillation_detect_control fields
	localparam int SCC_B_DETEN = 0;
	localparam int SCC_B_OCOSEL = 1;
	localparam int SCC_B_FLAG = 2;
	localparam int SCC_B_MON = 3;
	localparam int SCC_B_RSV2_LO = 4;
	localparam int SCC_B_RSV2_HI = 5;
	localparam int SCC_B_NOBIT = 6;
	localparam int SCC_B_ACTION = 7;
	// ------------------------------------------------------------
	// divide ratios and detector timing
	// ------------------------------------------------------------
	localparam logic [4:0] SCC_DIV_1 = 5'h01;
	localparam logic [4:0] SCC_DIV_2 = 5'h02;
	localparam logic [4:0] SCC_DIV_4 = 5'h04;
	localparam logic [4:0] SCC_DIV_8 = 5'h08;
	localparam logic [4:0] SCC_DIV_16 = 5'h10;
	localparam int SCC_STOP_TICKS = 4;
	typedef enum logic [1:0] {SCC_SRC_MAIN, SCC_SRC_PLL, SCC_SRC_ONCHIP}
		scc_src_type;
endpackage

// [hdl/scc_osc_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module scc_osc_monitor
	import scc_pkg::*;
#(
	parameter int STOP_TICKS = SCC_STOP_TICKS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// time base and observed oscillator
	input wire logic onchip_tick,
	input wire logic main_osc_level,
	// results
	output logic stopped,
	output logic stop_evt,
	output logic reosc_evt
);
	// ------------------------------------------------------------
	// edge watch on the main oscillator
	// ------------------------------------------------------------
	logic prev_reg;
	logic [7:0] cnt_reg;
	logic edge_seen;

	assign edge_seen = main_osc_level ^ prev_reg;

	// previous level of the oscillator
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_reg <= 1'b0;
		end else begin
			prev_reg <= main_osc_level;
		end
	end

	// silence counted in on-chip ticks
	always_ff @(posedge clk) begin
		if (!rst_n || edge_seen) begin
			cnt_reg <= 8'h00;
		end else if (onchip_tick && cnt_reg != 8'(STOP_TICKS)) begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// stopped level and one-cycle events
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stopped <= 1'b0;
			stop_evt <= 1'b0;
			reosc_evt <= 1'b0;
		end else begin
			stop_evt <= 1'b0;
			reosc_evt <= 1'b0;
			if (edge_seen && stopped) begin
				stopped <= 1'b0;
				reosc_evt <= 1'b1;
			end else if (!edge_seen && !stopped &&
				cnt_reg == 8'(STOP_TICKS)) begin
				stopped <= 1'b1;
				stop_evt <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_silence_stops;
		@(posedge clk) disable iff (!rst_n)
		(!stopped && !edge_seen && cnt_reg == 8'(STOP_TICKS))
			|=> (stopped && stop_evt);
	endproperty
	a_silence_stops: assert property (p_silence_stops)
		else $error("detector missed a silent main oscillator");
endmodule
`default_nettype wire

// [bench/scc_xtal_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// crystal on the main pins and on-chip oscillator time base
// ------------------------------------------------------------
module scc_xtal_model (
	// clock
	input wire logic clk,
	// control
	input wire logic run,
	input wire logic tick_en,
	// oscillator outputs
	output logic osc,
	output logic tick
);
	logic osc_reg = 1'b0;
	logic [1:0] cnt_reg = 2'h0;
	// crystal toggles while running, a stopped crystal holds its level
	always_ff @(posedge clk) begin
		if (run) begin
			osc_reg <= ~osc_reg;
		end
	end
	// one tick every four cycles, only while the oscillator is enabled
	always_ff @(posedge clk) begin
		cnt_reg <= cnt_reg + 2'h1;
	end
	assign osc = osc_reg;
	assign tick = tick_en && (cnt_reg == 2'h3);
endmodule
`default_nettype wire

// [bench/scc_top_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// self-checking bench
// ------------------------------------------------------------
module scc_top_tb_top;
	import scc_pkg::*;
	logic SYS_CLK = 1'b0, NRST = 1'b0, OSC_DET_RESET = 1'b0;
	logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
	logic WR = 1'b0, RD = 1'b0, CLOCK_CHANGE_LOCK = 1'b0, DIV8_SELECT = 1'b0;
	logic WAKE_EVENT = 1'b0, SUB_OSC_ENABLE = 1'b1, osc_run = 1'b1;
	logic ONCHIP_OSC_TICK, MAIN_OSC_IN, MAIN_OSC_DRIVE_HIGH, ONCHIP_OSC_EN;
	logic STOP_MODE, MAIN_OSC_OUT_HOLD, FEEDBACK_EN, SUB_OSC_IN_OE;
	logic SUB_OSC_OUT_OE, OSC_DETECT_IRQ, OSC_DETECT_RST_REQ;
	logic [4:0] MAIN_DIV_RATIO;
	scc_src_type SYS_SRC_SEL;
	int fails = 0, tests_run = 0, irq_cnt = 0, rst_cnt = 0;
	logic [31:0] seed = 32'hf352;
	logic [7:0] d;
	scc_top #(.ADDR_W(8), .STOP_TICKS(2)) scc_top_inst (.SYS_CLK(SYS_CLK),
		.NRST(NRST), .OSC_DET_RESET(OSC_DET_RESET), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.CLOCK_CHANGE_LOCK(CLOCK_CHANGE_LOCK), .DIV8_SELECT(DIV8_SELECT),
		.WAKE_EVENT(WAKE_EVENT), .SUB_OSC_ENABLE(SUB_OSC_ENABLE),
		.ONCHIP_OSC_TICK(ONCHIP_OSC_TICK), .MAIN_OSC_IN(MAIN_OSC_IN),
		.SYS_SRC_SEL(SYS_SRC_SEL), .MAIN_DIV_RATIO(MAIN_DIV_RATIO),
		.MAIN_OSC_DRIVE_HIGH(MAIN_OSC_DRIVE_HIGH),
		.ONCHIP_OSC_EN(ONCHIP_OSC_EN), .STOP_MODE(STOP_MODE),
		.MAIN_OSC_OUT_HOLD(MAIN_OSC_OUT_HOLD), .FEEDBACK_EN(FEEDBACK_EN),
		.SUB_OSC_IN_OE(SUB_OSC_IN_OE), .SUB_OSC_OUT_OE(SUB_OSC_OUT_OE),
		.OSC_DETECT_IRQ(OSC_DETECT_IRQ),
		.OSC_DETECT_RST_REQ(OSC_DETECT_RST_REQ));
	scc_xtal_model scc_xtal_model_inst (.clk(SYS_CLK),
		.run(osc_run && !STOP_MODE), .tick_en(ONCHIP_OSC_EN),
		.osc(MAIN_OSC_IN), .tick(ONCHIP_OSC_TICK));
	// ------------------------------------------------------------
	// clock, event counters, helpers
	// ------------------------------------------------------------
	initial begin
		forever #50 SYS_CLK = ~SYS_CLK;
	end
	// count one-cycle detection pulses
	always @(posedge SYS_CLK) begin
		irq_cnt <= irq_cnt + ((OSC_DETECT_IRQ === 1'b1) ? 1 : 0);
		rst_cnt <= rst_cnt + ((OSC_DETECT_RST_REQ === 1'b1) ? 1 : 0);
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// expected divisor from division field and divide-by-8 select
	function automatic logic [7:0] exp_div(input logic d8,
		input logic [1:0] f);
		if (d8) begin
			return 8'h08;
		end
		case (f)
			2'h0: return 8'h01;
			2'h1: return 8'h02;
			2'h2: return 8'h04;
			default: return 8'h10;
		endcase
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge SYS_CLK);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask
	// read one register and compare in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		#1;
		chk(RDATA, exp);
	endtask
	// wait for a number of detection pulses under a bound
	task automatic wait_evt(input int n);
		for (int i = 0; i < 300 && irq_cnt + rst_cnt != n; i++) begin
			idle(1);
		end
		idle(3);
	endtask
	task automatic do_reset(input logic det);
		@(posedge SYS_CLK);
		NRST <= 1'b0;
		OSC_DET_RESET <= det;
		repeat (3) @(posedge SYS_CLK);
		NRST <= 1'b1;
		OSC_DET_RESET <= 1'b0;
	endtask
	task automatic give_verdict();
		$display("counts: %0d compared, %0d bad", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// watchdog well beyond the expected run
	initial begin
		#(100 * 20000);
		fails++;
		give_verdict();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		do_reset(1'b0);
		idle(2);
		rchk(8'h07, SCC_CTRL1_RST);
		wr(8'h0c, 8'h40);
		rchk(8'h0c, 8'h00);
		chk({6'h0, SYS_SRC_SEL}, {6'h0, SCC_SRC_MAIN});
		$display("test reset done");
		// division field, divide-by-8, drive and on-chip stop
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			d = seed[7:0] & 8'hfc;
			if (i < 8) begin
				d[7:6] = i[1:0];
			end
			DIV8_SELECT <= (i < 8) ? i[2] : seed[9];
			wr(8'h07, d);
			idle(3);
			rchk(8'h07, d);
			chk({3'h0, MAIN_DIV_RATIO}, exp_div(DIV8_SELECT, d[7:6]));
			chk({7'h0, MAIN_OSC_DRIVE_HIGH}, {7'h0, d[5]});
			chk({7'h0, ONCHIP_OSC_EN}, {7'h0, ~d[4]});
		end
		DIV8_SELECT <= 1'b0;
		$display("test divide done");
		// unmapped place, then source selection
		wr(8'h08, seed[15:8]);
		rchk(8'h08, 8'h00);
		wr(8'h07, 8'h20);
		idle(20);
		wr(8'h07, 8'h22);
		idle(3);
		chk({6'h0, SYS_SRC_SEL}, {6'h0, SCC_SRC_PLL});
		wr(8'h0c, 8'h02);
		idle(3);
		chk({6'h0, SYS_SRC_SEL}, {6'h0, SCC_SRC_ONCHIP});
		wr(8'h0c, 8'h00);
		wr(8'h07, 8'h20);
		$display("test source done");
		// stop detection with interrupt action
		wr(8'h0c, 8'h81);
		osc_run <= 1'b0;
		wait_evt(1);
		chk(irq_cnt[7:0], 8'h01);
		chk({6'h0, SYS_SRC_SEL}, {6'h0, SCC_SRC_ONCHIP});
		rchk(8'h0c, 8'h8f);
		wr(8'h0c, 8'h8f);
		rchk(8'h0c, 8'h8f);
		wr(8'h0c, 8'h8b);
		rchk(8'h0c, 8'h8b);
		osc_run <= 1'b1;
		wait_evt(2);
		rchk(8'h0c, 8'h87);
		osc_run <= 1'b0;
		idle(60);
		chk(irq_cnt[7:0], 8'h02);
		chk(rst_cnt[7:0], 8'h00);
		osc_run <= 1'b1;
		wr(8'h0c, 8'h00);
		$display("test interrupt done");
		// detection disabled sees nothing
		idle(10);
		osc_run <= 1'b0;
		idle(60);
		rchk(8'h0c, 8'h08);
		osc_run <= 1'b1;
		// reset action, then a detection reset keeps bits 0, 1, 7
		idle(10);
		wr(8'h0c, 8'h03);
		osc_run <= 1'b0;
		wait_evt(3);
		chk(rst_cnt[7:0], 8'h01);
		osc_run <= 1'b1;
		idle(30);
		do_reset(1'b1);
		idle(2);
		rchk(8'h0c, 8'h03);
		rchk(8'h07, SCC_CTRL1_RST);
		CLOCK_CHANGE_LOCK <= 1'b1;
		wr(8'h0c, 8'h00);
		rchk(8'h0c, 8'h01);
		CLOCK_CHANGE_LOCK <= 1'b0;
		wr(8'h0c, 8'h00);
		rchk(8'h0c, 8'h00);
		$display("test detect reset done");
		// stop mode with detection off and main source selected
		chk({6'h0, SUB_OSC_IN_OE, SUB_OSC_OUT_OE}, 8'h03);
		wr(8'h07, 8'h01);
		idle(3);
		chk({7'h0, STOP_MODE}, 8'h01);
		chk({6'h0, MAIN_OSC_OUT_HOLD, FEEDBACK_EN}, 8'h02);
		chk({6'h0, SUB_OSC_IN_OE, SUB_OSC_OUT_OE}, 8'h00);
		chk({7'h0, ONCHIP_OSC_EN}, 8'h00);
		@(posedge SYS_CLK);
		WAKE_EVENT <= 1'b1;
		@(posedge SYS_CLK);
		WAKE_EVENT <= 1'b0;
		idle(3);
		chk({7'h0, STOP_MODE}, 8'h00);
		chk({6'h0, MAIN_OSC_OUT_HOLD, FEEDBACK_EN}, 8'h01);
		chk({6'h0, SUB_OSC_IN_OE, SUB_OSC_OUT_OE}, 8'h03);
		// sub pins stay undriven when the sub oscillator is unused
		SUB_OSC_ENABLE <= 1'b0;
		idle(3);
		chk({6'h0, SUB_OSC_IN_OE, SUB_OSC_OUT_OE}, 8'h00);
		$display("test stop mode done");
		give_verdict();
	end
endmodule
`default_nettype wire
